// ==== hw/fsq_pkg.sv ====
// Package with register map, field positions and event carriers of the flash status block.
package fsq_pkg;

   // Register byte addresses on the peripheral port.
   localparam logic [31:0] STATUS_ADDR     = 32'h407FE080;
   localparam logic [31:0] MODE_ENTRY_ADDR = 32'h407FE084;
   localparam logic [31:0] SETUP_INIT_ADDR = 32'h407FE08C;

   // Mode entry field layout and keys.
   localparam int          CODE_MODE_BIT   = 0;
   localparam int          DATA_MODE_BIT   = 7;
   localparam logic [7:0]  MODE_KEY        = 8'hAA;
   localparam logic [7:0]  SETUP_KEY       = 8'h2D;
   localparam logic [15:0] MODE_RESET      = 16'h0000;
   localparam logic [15:0] MODE_CODE_ONLY  = 16'h0001;
   localparam logic [15:0] MODE_DATA_ONLY  = 16'h0080;

   // Status word field positions.
   localparam int WPROT_BIT     = 6;
   localparam int PSUSP_BIT     = 8;
   localparam int ESUSP_BIT     = 9;
   localparam int BFULL_BIT     = 10;
   localparam int SRDY_BIT      = 11;
   localparam int PERR_BIT      = 12;
   localparam int EERR_BIT      = 13;
   localparam int ILLEGAL_BIT   = 14;
   localparam int READY_BIT     = 15;
   localparam int OTHER_BIT     = 20;
   localparam int SECURITY_BIT  = 21;
   localparam int SETTING_BIT   = 22;
   localparam int CMDCODE_BIT   = 23;
   localparam logic READY_RESET = 1'b1;

   // Default depth of the write-data buffer, in words.
   localparam int BUF_DEPTH     = 4;

   // Events reported by the command decoder and flash core, one-cycle pulses.
   typedef struct packed {
      logic protect_violation;  // Overwrite protection violated.
      logic prog_suspend_start; // Suspend processing begins during programming.
      logic erase_suspend_start; // Suspend processing begins during erasure.
      logic resume_received;    // Resume write to command area completed.
      logic suspend_received;   // Suspend write to command area completed.
      logic stop_received;      // Forced-stop write to command area completed.
      logic stop_start;         // Forced-stop processing begins.
      logic stop_done;          // Forced-stop processing has ended.
      logic clear_start;        // Status-clear processing begins.
      logic clear_done;         // Status-clear processing has ended.
      logic prog_fail;          // Programming failed.
      logic erase_fail;         // Erasure failed.
      logic illegal_cmd;        // Illegal request or illegal flash access.
      logic pe_started;         // Program or erase operation started.
      logic suspend_possible;   // Core reached a suspendable point.
      logic pe_complete;        // Program or erase operation completed.
      logic cmd_complete;       // Any command processing completed.
      logic suspend_halted;     // Suspend has halted programming.
      logic first_write;        // First write of a request to command area.
      logic last_write;         // Last write of a request to command area.
      logic req_prog_or_cfg;    // The request is program or configuration set.
      logic req_clear_or_stop;  // The request is status clear or forced stop.
      logic other_err;          // Other error detected.
      logic security_err;       // Security error detected.
      logic setting_err;        // Mode entry setting error detected.
      logic cmdcode_err;        // Illegal command code detected.
   } fsq_event_type;

   // Mode state shown to the flash core.
   typedef struct packed {
      logic code_flash_pe_mode; // Code flash in program/erase mode.
      logic data_flash_pe_mode; // Data flash in program/erase mode.
   } fsq_mode_type;

endpackage : fsq_pkg

// ==== hw/fsq_status.sv ====
// Status flags, write-data buffer and program/erase mode entry of the flash sequencer.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module fsq_status #(
   parameter int DEPTH = fsq_pkg::BUF_DEPTH  // Write-data buffer depth in words.
) (
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_en,
   input  wire logic [31:0]           reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   input  wire logic                  reg_wide,
   output var  logic [31:0]           reg_rdata,
   input  wire fsq_pkg::fsq_event_type seq_event,
   input  wire logic                  code_flash_access_error,
   input  wire logic                  data_flash_access_error,
   input  wire logic                  data_push,
   input  wire logic                  data_pop,
   output var  logic                  data_wait,
   output var  logic                  command_locked,
   output var  fsq_pkg::fsq_mode_type pe_mode
);

   // Width of the buffer fill counter.
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   // Status flags.
   logic write_protect_error_flag;    // Overwrite protection violated.
   logic program_suspend_status;      // Programming suspended or suspending.
   logic erase_suspend_status;        // Erasure suspended or suspending.
   logic write_buffer_full;           // Write-data buffer full.
   logic suspend_ready;               // Suspend request can be taken.
   logic program_error_flag;          // Programming failed.
   logic erase_error_flag;            // Erasure failed.
   logic illegal_request_flag;        // Illegal request or access seen.
   logic sequencer_ready;             // No command in progress.
   logic other_error_flag;            // Other error.
   logic security_error_flag;         // Security error.
   logic mode_entry_setting_error;    // Mode entry setting error.
   logic illegal_command_code_error;  // Illegal command code.
   logic pe_busy;                     // A program or erase operation runs.
   logic [CW-1:0] fill_count;         // Words held in the buffer.
   logic [CW-1:0] next_fill_count;    // Fill count after this cycle.

   // Bus decode and lock terms.
   logic mode_write;                  // Write to the mode entry register.
   logic init_write;                  // Accepted setup initialize write.
   logic mode_enabled;                // Mode write with ready and key.
   logic mode_zero;                   // Mode register now reads zero.
   logic mode_illegal;                // Written mode value is invalid.
   logic locked;                      // Any lock-causing flag set.
   logic accept_ok;                   // Request allowed under lock.
   logic access_err;                  // Either flash access error present.
   logic [31:0] status_word;          // Assembled status register.

   assign mode_write = reg_write && (reg_addr == fsq_pkg::MODE_ENTRY_ADDR);
   // Mode bits take written values only with ready, a full-width write and the right key.
   assign mode_enabled = mode_write && sequencer_ready && reg_wide &&
                         (reg_wdata[15:8] == fsq_pkg::MODE_KEY);
   assign mode_zero = !pe_mode.code_flash_pe_mode && !pe_mode.data_flash_pe_mode;
   // Setting both bits from zero gives 0081h, which is neither legal value.
   assign mode_illegal = mode_enabled && mode_zero &&
                         reg_wdata[fsq_pkg::CODE_MODE_BIT] &&
                         reg_wdata[fsq_pkg::DATA_MODE_BIT];
   // Setup initialize needs ready, a full-width write, key 2Dh and bit 0 set.
   assign init_write = reg_write && (reg_addr == fsq_pkg::SETUP_INIT_ADDR) &&
                       sequencer_ready && reg_wide && reg_wdata[0] &&
                       (reg_wdata[15:8] == fsq_pkg::SETUP_KEY);
   assign access_err = code_flash_access_error || data_flash_access_error;
   // Every lock-causing flag holds the sequencer command-locked.
   assign locked = write_protect_error_flag || program_error_flag ||
                   erase_error_flag || illegal_request_flag ||
                   other_error_flag || security_error_flag ||
                   mode_entry_setting_error || illegal_command_code_error;
   assign accept_ok = !locked || seq_event.req_clear_or_stop;

   // Buffer count: a push is taken only when space remains.
   always_comb begin
      next_fill_count = fill_count;
      if (data_push && (fill_count != FULL_COUNT) && !(data_pop && fill_count != '0)) begin
         next_fill_count = fill_count + CW'(1);
      end else if (data_pop && (fill_count != '0) &&
                   !(data_push && fill_count != FULL_COUNT)) begin
         next_fill_count = fill_count - CW'(1);
      end
   end

   // Fill counter and the bus wait it drives.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fill_count <= '0;
         data_wait  <= 1'b0;
      end else if (clk_en) begin
         fill_count <= next_fill_count;
         // The master holds its data write while this is high.
         data_wait  <= (next_fill_count == FULL_COUNT);
      end
   end

   // Buffer-full flag follows fill and drain edges, not every count change.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         write_buffer_full <= 1'b0;
      end else if (clk_en) begin
         if (next_fill_count == FULL_COUNT) begin
            write_buffer_full <= 1'b1;
         end else if (next_fill_count == '0) begin
            write_buffer_full <= 1'b0;
         end
      end
   end

   // Write protect error: only a forced stop clears it.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         write_protect_error_flag <= 1'b0;
      end else if (clk_en) begin
         if (seq_event.protect_violation) begin
            write_protect_error_flag <= 1'b1;
         end else if (seq_event.stop_start) begin
            write_protect_error_flag <= 1'b0;
         end
      end
   end

   // Suspend status flags; a new suspend wins over a simultaneous clear.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         program_suspend_status <= 1'b0;
         erase_suspend_status   <= 1'b0;
      end else if (clk_en) begin
         if (seq_event.prog_suspend_start) begin
            program_suspend_status <= 1'b1;
         end else if (seq_event.resume_received || seq_event.stop_start) begin
            program_suspend_status <= 1'b0;
         end
         if (seq_event.erase_suspend_start) begin
            erase_suspend_status <= 1'b1;
         end else if (seq_event.resume_received || seq_event.stop_start) begin
            erase_suspend_status <= 1'b0;
         end
      end
   end

   // Tracks whether a program or erase operation is under way.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pe_busy <= 1'b0;
      end else if (clk_en) begin
         if (seq_event.pe_started) begin
            pe_busy <= 1'b1;
         end else if (seq_event.pe_complete || seq_event.stop_start) begin
            pe_busy <= 1'b0;
         end
      end
   end

   // Suspend ready: only meaningful while an operation runs.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         suspend_ready <= 1'b0;
      end else if (clk_en) begin
         if (seq_event.suspend_possible && pe_busy && !locked) begin
            suspend_ready <= 1'b1;
         end else if (seq_event.suspend_received || seq_event.stop_received ||
                      (locked && pe_busy) || seq_event.pe_complete) begin
            suspend_ready <= 1'b0;
         end
      end
   end

   // Program and erase error flags, cleared as clear or stop begins.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         program_error_flag <= 1'b0;
         erase_error_flag   <= 1'b0;
      end else if (clk_en) begin
         if (seq_event.prog_fail) begin
            program_error_flag <= 1'b1;
         end else if (seq_event.clear_start || seq_event.stop_start) begin
            program_error_flag <= 1'b0;
         end
         if (seq_event.erase_fail) begin
            erase_error_flag <= 1'b1;
         end else if (seq_event.clear_start || seq_event.stop_start) begin
            erase_error_flag <= 1'b0;
         end
      end
   end

   // Illegal flag: a forced stop always drops it for the stop's duration,
   // a status clear only when no access error is pending, and either one
   // raises it again at its end if an access error is still present.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         illegal_request_flag <= 1'b0;
      end else if (clk_en) begin
         if (seq_event.illegal_cmd || mode_illegal) begin
            illegal_request_flag <= 1'b1;
         end else if ((seq_event.stop_done || seq_event.clear_done) && access_err) begin
            illegal_request_flag <= 1'b1;
         end else if (seq_event.stop_start ||
                      (seq_event.clear_start && !access_err)) begin
            illegal_request_flag <= 1'b0;
         end
      end
   end

   // Four further lock-causing errors, cleared when clear or stop ends.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         other_error_flag           <= 1'b0;
         security_error_flag        <= 1'b0;
         mode_entry_setting_error   <= 1'b0;
         illegal_command_code_error <= 1'b0;
      end else if (clk_en) begin
         if (seq_event.other_err) begin
            other_error_flag <= 1'b1;
         end else if (seq_event.clear_done || seq_event.stop_done) begin
            other_error_flag <= 1'b0;
         end
         if (seq_event.security_err) begin
            security_error_flag <= 1'b1;
         end else if (seq_event.clear_done || seq_event.stop_done) begin
            security_error_flag <= 1'b0;
         end
         if (seq_event.setting_err) begin
            mode_entry_setting_error <= 1'b1;
         end else if (seq_event.clear_done || seq_event.stop_done) begin
            mode_entry_setting_error <= 1'b0;
         end
         if (seq_event.cmdcode_err) begin
            illegal_command_code_error <= 1'b1;
         end else if (seq_event.clear_done || seq_event.stop_done) begin
            illegal_command_code_error <= 1'b0;
         end
      end
   end

   // Ready flag; a completion in the same cycle as an accept keeps it set.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sequencer_ready <= fsq_pkg::READY_RESET;
      end else if (clk_en) begin
         if (seq_event.cmd_complete || seq_event.suspend_halted ||
             seq_event.stop_done) begin
            sequencer_ready <= 1'b1;
         end else if (accept_ok &&
                      ((seq_event.first_write && seq_event.req_prog_or_cfg) ||
                       (seq_event.last_write && !seq_event.req_prog_or_cfg))) begin
            sequencer_ready <= 1'b0;
         end
      end
   end

   // Command lock level for the decoder, which refuses other requests.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         command_locked <= 1'b0;
      end else if (clk_en) begin
         command_locked <= locked;
      end
   end

   // Mode entry register. Key bits are not stored, so only two flops exist.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || (clk_en && init_write)) begin
         pe_mode <= '0;
      end else if (clk_en && mode_write && sequencer_ready) begin
         if (mode_enabled && mode_zero) begin
            // From zero, each bit takes the written value.
            pe_mode.code_flash_pe_mode <= reg_wdata[fsq_pkg::CODE_MODE_BIT];
            pe_mode.data_flash_pe_mode <= reg_wdata[fsq_pkg::DATA_MODE_BIT];
         end else begin
            // Narrow write, wrong key, or any enabled write while set.
            pe_mode <= '0;
         end
      end
   end

   // Status word; reserved bits read as zero.
   always_comb begin
      status_word                          = '0;
      status_word[fsq_pkg::WPROT_BIT]      = write_protect_error_flag;
      status_word[fsq_pkg::PSUSP_BIT]      = program_suspend_status;
      status_word[fsq_pkg::ESUSP_BIT]      = erase_suspend_status;
      status_word[fsq_pkg::BFULL_BIT]      = write_buffer_full;
      status_word[fsq_pkg::SRDY_BIT]       = suspend_ready;
      status_word[fsq_pkg::PERR_BIT]       = program_error_flag;
      status_word[fsq_pkg::EERR_BIT]       = erase_error_flag;
      status_word[fsq_pkg::ILLEGAL_BIT]    = illegal_request_flag;
      status_word[fsq_pkg::READY_BIT]      = sequencer_ready;
      status_word[fsq_pkg::OTHER_BIT]      = other_error_flag;
      status_word[fsq_pkg::SECURITY_BIT]   = security_error_flag;
      status_word[fsq_pkg::SETTING_BIT]    = mode_entry_setting_error;
      status_word[fsq_pkg::CMDCODE_BIT]    = illegal_command_code_error;
   end

   // Read port: data stand one cycle after the strobe; unmapped reads zero.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= '0;
         if (reg_read) begin
            unique case (reg_addr)
               fsq_pkg::STATUS_ADDR: begin
                  reg_rdata <= status_word;
               end
               fsq_pkg::MODE_ENTRY_ADDR: begin
                  // Key field reads zero since it is never retained.
                  reg_rdata[fsq_pkg::CODE_MODE_BIT] <= pe_mode.code_flash_pe_mode;
                  reg_rdata[fsq_pkg::DATA_MODE_BIT] <= pe_mode.data_flash_pe_mode;
               end
               default: begin
                  reg_rdata <= '0;
               end
            endcase
         end
      end
   end

endmodule : fsq_status

`default_nettype wire

// ==== tb/fsq_status_assertions.sv ====
// Port-level checks of the flash status block.
`timescale 1ns/10ps
`default_nettype none
module fsq_status_assertions #(
   parameter int DEPTH = 4  // Buffer depth in words.
) (
   input wire logic                   clk_sys,
   input wire logic                   sys_rst,
   input wire logic [31:0]            reg_addr,
   input wire logic [31:0]            reg_wdata,
   input wire logic                   reg_write,
   input wire logic                   reg_read,
   input wire logic                   reg_wide,
   input wire logic [31:0]            reg_rdata,
   input wire fsq_pkg::fsq_event_type seq_event,
   input wire logic                   data_push,
   input wire logic                   data_pop,
   input wire logic                   data_wait,
   input wire logic                   command_locked,
   input wire fsq_pkg::fsq_mode_type  pe_mode
);
   int   cnt;  // Buffer fill as the ports show it.
   logic rdy;  // Ready shadow; lock gating is left out, so the bench never needs it.
   logic err;  // Any of the eight error events that set a lock-causing flag.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   assign err = |{seq_event.protect_violation, seq_event.prog_fail, seq_event.erase_fail,
                  seq_event.illegal_cmd, seq_event.other_err, seq_event.security_err,
                  seq_event.setting_err, seq_event.cmdcode_err};
   // Pushes into a full buffer are dropped, so they must not count.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) cnt <= 0;
      else cnt <= cnt + int'(data_push && !data_wait) - int'(data_pop && cnt != 0);
   end
   // Ready falls on a request write and rises when processing ends.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) rdy <= 1'b1;
      else if (seq_event.cmd_complete || seq_event.suspend_halted || seq_event.stop_done)
         rdy <= 1'b1;
      else if (seq_event.first_write || seq_event.last_write) rdy <= 1'b0;
   end
   sequence s_mode_wr;
      reg_write && reg_addr == fsq_pkg::MODE_ENTRY_ADDR;
   endsequence
   sequence s_bad_wr;
      s_mode_wr ##0 (rdy && (!reg_wide || reg_wdata[15:8] != 8'hAA || pe_mode != 2'b00));
   endsequence
   a_reset_idle: assert property ($fell(sys_rst) |-> pe_mode == 2'b00 && !data_wait)
      else $error("not idle after reset");
   a_mode_enter: assert property (s_mode_wr ##0 (rdy && reg_wide && pe_mode == 2'b00 &&
      reg_wdata[15:0] == 16'hAA01) |=> pe_mode == 2'b10) else $error("mode not entered");
   a_mode_drop: assert property (s_bad_wr |=> pe_mode == 2'b00)
      else $error("mode not cleared");
   a_mode_hold: assert property (s_mode_wr ##0 !rdy |=> $stable(pe_mode))
      else $error("mode changed while busy");
   a_buf_wait: assert property (data_wait == (cnt == DEPTH))
      else $error("wait not tied to full buffer");
   a_err_lock: assert property (err |-> ##2 command_locked)
      else $error("error did not lock");
   a_lock_cause: assert property ($rose(command_locked) |->
      $past(err || reg_write || seq_event.stop_done || seq_event.clear_done, 2))
      else $error("lock without cause");
   a_read_gap: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data outside read");
   a_stat_rsvd: assert property (reg_read && reg_addr == fsq_pkg::STATUS_ADDR |=>
      (reg_rdata & 32'hFF0F00BF) == 32'h0) else $error("status reserved bits");
   a_mode_rsvd: assert property (reg_read && reg_addr == fsq_pkg::MODE_ENTRY_ADDR |=>
      (reg_rdata & 32'hFFFFFF7E) == 32'h0) else $error("mode reserved bits");
endmodule : fsq_status_assertions
`default_nettype wire

// ==== tb/fsq_core_model.sv ====
// Slow flash core that drains the write buffer.
`timescale 1ns/10ps
`default_nettype none
module fsq_core_model (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic data_push,
   input  wire logic data_wait,
   input  wire logic hold,
   output var  logic data_pop
);
   int   held;   // Words the core knows are waiting.
   logic phase;  // Only every other cycle, so the buffer can fill.
   // The core counts accepted words so it never pops an empty buffer.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         held  <= 0;
         phase <= 1'b0;
      end else begin
         phase <= !phase;
         held  <= held + int'(data_push && !data_wait) - int'(data_pop);
      end
   end
   // A stalled core leaves the buffer full.
   assign data_pop = !hold && held != 0 && phase;
endmodule : fsq_core_model
`default_nettype wire

// ==== tb/fsq_status_tb.sv ====
// Self-checking bench of the flash status block.
`timescale 1ns/10ps
`default_nettype none
module fsq_status_tb;
   localparam logic [31:0] ST = fsq_pkg::STATUS_ADDR;
   localparam logic [31:0] MD = fsq_pkg::MODE_ENTRY_ADDR;
   logic clk_sys = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, reg_wide = 1'b0;
   logic code_flash_access_error = 1'b0, data_flash_access_error = 1'b0, clk_en = 1'b1;
   logic data_push = 1'b0, hold = 1'b1, w, data_pop, data_wait, command_locked;
   logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
   logic [15:0] cur, d;  // Expected mode value and random write data.
   fsq_pkg::fsq_event_type seq_event = '0;
   fsq_pkg::fsq_mode_type  pe_mode;
   int error_cnt = 0, num_checks = 0;
   int ebit[8] = '{25, 15, 14, 13, 3, 2, 1, 0};   // Error event positions.
   int sbit[8] = '{6, 12, 13, 14, 20, 21, 22, 23}; // Matching status bits.
   always #20 clk_sys = ~clk_sys;
   fsq_status #(.DEPTH(4)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_wide(reg_wide), .reg_rdata(reg_rdata), .seq_event(seq_event),
      .code_flash_access_error(code_flash_access_error),
      .data_flash_access_error(data_flash_access_error), .data_push(data_push),
      .data_pop(data_pop), .data_wait(data_wait), .command_locked(command_locked),
      .pe_mode(pe_mode));
   fsq_core_model core_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .data_push(data_push),
      .data_wait(data_wait), .hold(hold), .data_pop(data_pop));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   // Pulses one or two event fields for a single cycle.
   task automatic ev(input int a, input int b = 26);
      logic [25:0] m;
      m = '0;
      m[a] = 1'b1;
      if (b < 26) m[b] = 1'b1;
      @(posedge clk_sys);
      seq_event <= m;
      @(posedge clk_sys);
      seq_event <= '0;
   endtask : ev
   task automatic wr(input logic [31:0] a, input logic [15:0] v, input logic wide);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= {16'h0, v};
      reg_wide  <= wide;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask : rd
   // Next mode value for a write while ready is high.
   function automatic logic [15:0] f_mode(input logic [15:0] c, input logic wd,
                                          input logic [15:0] v);
      if (!wd || v[15:8] != 8'hAA || c != 16'h0) return 16'h0;
      return {8'h0, v[7], 6'h0, v[0]};
   endfunction : f_mode
   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      void'($urandom(32'h764D));
      rd(ST, 32'h8000, "status");
      rd(MD, 32'h0, "mode");
      rd(32'h407FE0F0, 32'h0, "unmapped");
      cur = 16'h0;
      repeat (30) begin
         w = $urandom_range(0, 3) != 0;
         d = {($urandom_range(0, 2) != 0) ? 8'hAA : 8'($urandom), 8'($urandom) & 8'h81};
         wr(MD, d, w);
         cur = f_mode(cur, w, d);
         rd(MD, {16'h0, cur}, "mode");
      end
      wr(MD, 16'h0, 1'b0);
      wr(MD, 16'hAA81, 1'b1);
      rd(ST, 32'hC000, "illegal mode");
      wr(fsq_pkg::SETUP_INIT_ADDR, 16'h2D01, 1'b1);
      rd(MD, 32'h0, "mode after init");
      ev(19);
      ev(18);
      wr(MD, 16'hAA80, 1'b1);
      $display("mode test done");
      ev(7, 5);
      rd(ST, 32'h0, "ready");
      wr(MD, 16'hAA00, 1'b1);
      rd(MD, 32'h80, "mode while busy");
      ev(9);
      rd(ST, 32'h8000, "ready");
      ev(6);
      rd(ST, 32'h0, "ready");
      ev(8);
      rd(ST, 32'h8000, "ready");
      $display("ready test done");
      foreach (ebit[i]) begin
         ev(ebit[i]);
         rd(ST, 32'h8000 | (32'h1 << sbit[i]), "error flag");
         chk("lock", 32'h1, {31'h0, command_locked});
         if (i == 0) ev(19);
         else ev(17);
         ev(i == 0 ? 18 : 16);
         rd(ST, 32'h8000, "error cleared");
      end
      {code_flash_access_error, data_flash_access_error} <= $urandom_range(0, 1) ? 2'b10 : 2'b01;
      ev(13);
      ev(19);
      rd(ST, 32'h8000, "illegal in stop");
      ev(18);
      rd(ST, 32'hC000, "illegal after stop");
      {code_flash_access_error, data_flash_access_error} <= 2'b00;
      ev(17);
      ev(16);
      rd(ST, 32'h8000, "illegal after clear");
      $display("error test done");
      ev(12);
      ev(11);
      rd(ST, 32'h8800, "suspend ready");
      ev(21);
      rd(ST, 32'h8000, "suspend ready");
      ev(12);
      ev(11);
      ev(10);
      rd(ST, 32'h8000, "suspend ready");
      ev(24);
      rd(ST, 32'h8100, "program suspend");
      ev(22);
      rd(ST, 32'h8000, "resume");
      ev(23);
      // A frozen block must ignore this stop.
      clk_en <= 1'b0;
      ev(19);
      clk_en <= 1'b1;
      rd(ST, 32'h8200, "erase suspend");
      ev(19);
      rd(ST, 32'h8000, "stop");
      ev(18);
      $display("suspend test done");
      data_push <= 1'b1;
      repeat (5) @(posedge clk_sys);
      data_push <= 1'b0;
      rd(ST, 32'h8400, "buffer full");
      chk("bus wait", 32'h1, {31'h0, data_wait});
      repeat (20) @(posedge clk_sys) hold <= $urandom_range(0, 2) == 0;
      hold <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd(ST, 32'h8000, "buffer empty");
      $display("buffer test done");
      final_report();
   end
endmodule : fsq_status_tb
bind fsq_status fsq_status_assertions #(.DEPTH(DEPTH)) chk_u (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_wide(reg_wide), .reg_rdata(reg_rdata), .seq_event(seq_event),
   .data_push(data_push), .data_pop(data_pop), .data_wait(data_wait),
   .command_locked(command_locked), .pe_mode(pe_mode));
`default_nettype wire
